// [verilog/lbt_bridge_top.sv]
// lbt_bridge_top: local bus transfer start, transaction code and size pins
`timescale 1ns/1ps
`default_nettype none
module lbt_bridge_top
  import lbt_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // master request from the target image
  input  wire logic        mstReq,
  input  wire lbt_fields_t mstFields,
  output logic             mstReady,
  output logic             mstSizeErr,
  input  wire logic        busOwner,
  input  wire logic        mstEnd,
  output logic             mstBusy,
  // slave side results
  output logic             slvValid,
  output lbt_slave_t       slvInfo,
  output logic             slvMiss,
  // selects and dma acknowledge
  input  wire logic        pciImageSelectN,
  input  wire logic        registerSelectN,
  input  wire logic        dmaAcknowledgeN,
  // transfer start pin
  input  wire logic        transferStartNIn,
  output logic             transferStartNOut,
  output logic             transferStartNOeN,
  // address, code, size and direction pins
  input  wire lbt_fields_t busFieldsIn,
  output lbt_fields_t      busFieldsOut,
  output logic             busFieldsOeN
);
  typedef enum logic [1:0] {M_IDLE, M_START, M_HOLD} lbt_mst_state_t;

  lbt_mst_state_t state_q;
  lbt_mst_state_t state_d;
  lbt_fields_t    drive_q;
  logic           tsOut_q;
  logic           tsOeN_q;
  logic           fldOeN_q;
  logic           sizeErr_q;
  lbt_fields_t    capt_q;
  logic           isDma_q;
  logic           slvStart_q;

  // master side decode
  wire sizeReserved = (mstFields.size == SIZE_THREE);
  wire idle         = (state_q == M_IDLE);
  wire accept       = mstReq && busOwner && idle && !sizeReserved;
  wire refuse       = mstReq && busOwner && idle && sizeReserved;
  wire driving      = !tsOeN_q;

  // slave side decode
  wire slvSeen  = !driving && (transferStartNIn == TS_ASSERTED);
  wire dmaCycle = (busFieldsIn.code == CODE_DMA) && !dmaAcknowledgeN;

  always_comb begin
    state_d = state_q;
    case (state_q)
      M_IDLE:  if (accept) state_d = M_START;
      M_START: state_d = M_HOLD;
      M_HOLD:  if (mstEnd) state_d = M_IDLE;
      default: state_d = M_IDLE;
    endcase
  end

  // master pin drivers, all launched from rising edges
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q   <= M_IDLE;
      drive_q   <= FIELDS_RST;
      tsOut_q   <= TS_NEGATED;
      tsOeN_q   <= OE_FLOAT;
      fldOeN_q  <= OE_FLOAT;
      sizeErr_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      sizeErr_q <= refuse;
      if (accept) begin
        drive_q <= mstFields;
      end
      // strobe low for one cycle after the launch edge
      tsOut_q  <= (state_d == M_START) ? TS_ASSERTED : TS_NEGATED;
      tsOeN_q  <= (state_d == M_IDLE) ? OE_FLOAT : OE_DRIVE;
      fldOeN_q <= (state_d == M_IDLE) ? OE_FLOAT : OE_DRIVE;
    end
  end

  // slave capture on the edge that sees the strobe low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      capt_q     <= FIELDS_RST;
      isDma_q    <= 1'b0;
      slvStart_q <= 1'b0;
    end else begin
      slvStart_q <= slvSeen;
      if (slvSeen) begin
        capt_q  <= busFieldsIn;
        isDma_q <= dmaCycle;
      end
    end
  end

  logic hitRegs;

  lbt_slave_select u_sel (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .start           (slvStart_q),
    .pciImageSelectN (pciImageSelectN),
    .registerSelectN (registerSelectN),
    .hit             (slvValid),
    .hitRegs         (hitRegs),
    .miss            (slvMiss)
  );

  assign mstReady          = busOwner && idle && !sizeReserved;
  assign mstSizeErr        = sizeErr_q;
  assign mstBusy           = !idle;
  assign transferStartNOut = tsOut_q;
  assign transferStartNOeN = tsOeN_q;
  assign busFieldsOut      = drive_q;
  assign busFieldsOeN      = fldOeN_q;
  assign slvInfo = '{
    fields:    capt_q,
    byteCount: lbt_byte_count(capt_q.size),
    isDma:     isDma_q,
    toRegs:    hitRegs
  };

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ts_pulse_a: assert property (
    accept |=> transferStartNOut == TS_ASSERTED && !transferStartNOeN
      ##1 transferStartNOut == TS_NEGATED && !transferStartNOeN)
    else $error("start strobe not one cycle low after accept");

  ts_release_a: assert property (
    $rose(transferStartNOeN) |-> $past(transferStartNOut) == TS_NEGATED)
    else $error("start strobe floated while low");

  float_idle_a: assert property (
    idle |-> transferStartNOeN == OE_FLOAT && busFieldsOeN == OE_FLOAT)
    else $error("pins driven while not master");

  code_timing_a: assert property (
    accept |=> busFieldsOeN == OE_DRIVE
      && busFieldsOut == $past(mstFields))
    else $error("code or address not launched with start");

  fields_stable_a: assert property (
    !busFieldsOeN && !$rose(busFieldsOeN) && !$fell(busFieldsOeN)
      |-> $stable(busFieldsOut))
    else $error("driven fields changed mid transaction");

  size_reserved_a: assert property (
    refuse |=> mstSizeErr && idle)
    else $error("reserved size accepted as master");

  slave_capture_a: assert property (
    slvSeen |=> slvInfo.fields == $past(busFieldsIn))
    else $error("slave fields not captured on strobe edge");

  dma_decode_a: assert property (
    slvSeen |=> slvInfo.isDma == ($past(busFieldsIn.code) == CODE_DMA
      && !$past(dmaAcknowledgeN)))
    else $error("dma decode wrong");

  no_self_slave_a: assert property (
    driving |=> !slvStart_q)
    else $error("own strobe taken as slave start");

  ts_float_high_a: assert property (
    transferStartNOeN == OE_FLOAT |-> transferStartNOut == TS_NEGATED)
    else $error("strobe value low while floated");

  strobe_once_a: assert property (
    transferStartNOut == TS_ASSERTED |=> transferStartNOut == TS_NEGATED)
    else $error("start strobe low for more than one cycle");

  strobe_cause_a: assert property (
    $fell(transferStartNOut) |-> $past(accept))
    else $error("start strobe without accepted request");

  end_release_a: assert property (
    state_q == M_HOLD && mstEnd |=> transferStartNOeN == OE_FLOAT
      && busFieldsOeN == OE_FLOAT && !mstBusy)
    else $error("pins not floated after end");

  busy_drive_a: assert property (
    mstBusy |-> transferStartNOeN == OE_DRIVE && busFieldsOeN == OE_DRIVE)
    else $error("pins floated while master");

  size_out_a: assert property (
    busFieldsOeN == OE_DRIVE |-> busFieldsOut.size != SIZE_THREE)
    else $error("reserved size driven as master");

  slave_hold_a: assert property (
    !slvSeen |=> $stable(slvInfo.fields))
    else $error("slave fields changed without strobe");

  count_decode_a: assert property (
    slvInfo.byteCount == {slvInfo.fields.size == SIZE_FOUR,
      slvInfo.fields.size})
    else $error("byte count decode wrong");

  owner_gate_a: assert property (
    !busOwner && idle |=> idle)
    else $error("master cycle started without bus");
endmodule : lbt_bridge_top
`default_nettype wire

// [verilog/lbt_pkg.sv]
// lbt_pkg: constants and carrier types for the local bus start/code block
`default_nettype none
package lbt_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 25;
  // slave select window, in clock cycles after the start edge
  localparam int SEL_WAIT_CYC = 3;
  localparam logic [1:0] SEL_CNT_LAST = 2'(SEL_WAIT_CYC);
  // field widths
  localparam int ADDR_W = 32;
  localparam int CODE_W = 4;
  localparam int SIZE_W = 2;
  // byte count codes
  localparam logic [1:0] SIZE_FOUR  = 2'h0;
  localparam logic [1:0] SIZE_ONE   = 2'h1;
  localparam logic [1:0] SIZE_TWO   = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;
  // transaction code that marks an independent dma cycle
  localparam logic [3:0] CODE_DMA = 4'hF;
  // direction levels
  localparam logic DIR_READ  = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // pin levels
  localparam logic TS_ASSERTED = 1'b0;
  localparam logic TS_NEGATED  = 1'b1;
  localparam logic OE_DRIVE    = 1'b0;
  localparam logic OE_FLOAT    = 1'b1;
  // reset values
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [3:0]  CODE_RST = 4'h0;

  // strobe-qualified bus fields
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CODE_W-1:0] code;
    logic [SIZE_W-1:0] size;
    logic              rd;
  } lbt_fields_t;

  // decoded slave access
  typedef struct packed {
    lbt_fields_t fields;
    logic [2:0]  byteCount;
    logic        isDma;
    logic        toRegs;
  } lbt_slave_t;

  localparam lbt_fields_t FIELDS_RST =
    '{addr: ADDR_RST, code: CODE_RST, size: SIZE_FOUR, rd: DIR_WRITE};

  // byte count from size code; three bytes only meaningful as slave
  function automatic logic [2:0] lbt_byte_count(input logic [1:0] sz);
    logic [2:0] n;
    n = 3'h4;
    case (sz)
      SIZE_ONE:   n = 3'h1;
      SIZE_TWO:   n = 3'h2;
      SIZE_THREE: n = 3'h3;
      default:    n = 3'h4;
    endcase
    return n;
  endfunction
endpackage : lbt_pkg
`default_nettype wire

// [verilog/lbt_slave_select.sv]
// lbt_slave_select: waits for a chip select after a slave start
`timescale 1ns/1ps
`default_nettype none
module lbt_slave_select
  import lbt_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // start of a slave cycle
  input  wire logic start,
  // selects from the image decode
  input  wire logic pciImageSelectN,
  input  wire logic registerSelectN,
  // result
  output logic      hit,
  output logic      hitRegs,
  output logic      miss
);
  logic       active_q;
  logic       active_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       hit_q;
  logic       hitRegs_q;
  logic       miss_q;

  wire anySel  = !pciImageSelectN || !registerSelectN;
  wire looking = start || active_q;
  wire seen    = looking && anySel;
  wire lastCyc = active_q && (cnt_q == SEL_CNT_LAST);
  wire expire  = !start && lastCyc && !anySel;

  // window of up to three cycles after the start edge
  assign active_d = start ? !anySel : (active_q && !anySel && !lastCyc);
  assign cnt_d    = start ? 2'h1 : (active_q ? cnt_q + 2'h1 : 2'h0);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_q  <= 1'b0;
      cnt_q     <= 2'h0;
      hit_q     <= 1'b0;
      hitRegs_q <= 1'b0;
      miss_q    <= 1'b0;
    end else begin
      active_q  <= active_d;
      cnt_q     <= cnt_d;
      hit_q     <= seen;
      hitRegs_q <= seen && !registerSelectN;
      miss_q    <= expire;
    end
  end

  assign hit     = hit_q;
  assign hitRegs = hitRegs_q;
  assign miss    = miss_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sel_window_a: assert property (
    start && !anySel ##1 !anySel [*3] |=> miss)
    else $error("no miss after three cycles without select");
  late_sel_a: assert property (
    start && !anySel ##1 !anySel ##1 !anySel ##1 anySel |=> hit)
    else $error("select in third wait cycle not taken");
  hit_once_a: assert property (hit |=> !hit || $past(start, 1))
    else $error("hit repeated without new start");
endmodule : lbt_slave_select
`default_nettype wire

// [tb/lbt_proc_model.sv]
// lbt_proc_model: far-side processor making slave cycles on the wires
`timescale 1ns/1ps
`default_nettype none
module lbt_proc_model
  import lbt_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  // cycle request from the bench
  input  wire logic        go,
  input  wire lbt_fields_t fld,
  // device pin drives
  input  wire logic        devTsOut,
  input  wire logic        devTsOeN,
  input  wire lbt_fields_t devFldOut,
  input  wire logic        devFldOeN,
  // resolved wires
  output logic             tsWire,
  output lbt_fields_t      fldWire
);
  logic        drvQ = 1'b0;
  lbt_fields_t fldQ = FIELDS_RST;
  // strobe low one cycle; fields valid only at its edge, then scrambled
  always @(posedge ref_clk) begin
    drvQ <= go;
    fldQ <= go ? fld : ~fldQ;
  end
  // strobe pulled up when nobody drives it
  assign tsWire  = (devTsOeN == OE_DRIVE) ? devTsOut
                 : (drvQ ? TS_ASSERTED : TS_NEGATED);
  assign fldWire = (devFldOeN == OE_DRIVE) ? devFldOut : fldQ;
endmodule : lbt_proc_model
`default_nettype wire

// [tb/tb.sv]
// tb: self-checking bench for the start strobe and code block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lbt_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        mstReq = 1'b0;
  logic        busOwner = 1'b0;
  logic        mstEnd = 1'b0;
  logic        go = 1'b0;
  logic        pciImageSelectN = 1'b1;
  logic        registerSelectN = 1'b1;
  logic        dmaAcknowledgeN = 1'b1;
  lbt_fields_t mstFields = FIELDS_RST;
  lbt_fields_t pFld = FIELDS_RST;
  logic        mstReady, mstSizeErr, mstBusy, slvValid, slvMiss;
  logic        tsOut, tsOeN, fldOeN, tsWire;
  lbt_slave_t  slvInfo;
  lbt_fields_t fldOut, fldWire;
  int          mismatches = 0;
  int          nChecks = 0;

  always #12.5 ref_clk = ~ref_clk;

  lbt_bridge_top i_lbt_bridge_top (
    .ref_clk(ref_clk), .rst(rst), .mstReq(mstReq), .mstFields(mstFields),
    .mstReady(mstReady), .mstSizeErr(mstSizeErr), .busOwner(busOwner),
    .mstEnd(mstEnd), .mstBusy(mstBusy), .slvValid(slvValid),
    .slvInfo(slvInfo), .slvMiss(slvMiss), .pciImageSelectN(pciImageSelectN),
    .registerSelectN(registerSelectN), .dmaAcknowledgeN(dmaAcknowledgeN),
    .transferStartNIn(tsWire), .transferStartNOut(tsOut),
    .transferStartNOeN(tsOeN), .busFieldsIn(fldWire),
    .busFieldsOut(fldOut), .busFieldsOeN(fldOeN));

  lbt_proc_model i_lbt_proc_model (
    .ref_clk(ref_clk), .go(go), .fld(pFld), .devTsOut(tsOut),
    .devTsOeN(tsOeN), .devFldOut(fldOut), .devFldOeN(fldOeN),
    .tsWire(tsWire), .fldWire(fldWire));

  task automatic tick();
    @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input bit ok, input string m);
    nChecks++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end
    else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // master cycle: start pulse, driven fields, negate, float on end
  task automatic master_ok(input logic [1:0] sz, input logic rd);
    lbt_fields_t f;
    f = '{addr: 32'hA5C3_0F10 ^ {30'h0, sz}, code: {rd, 1'b0, sz},
          size: sz, rd: rd};
    mstFields = f;
    mstReq = 1'b1;
    #1 chk(mstReady === 1'b1, "request not ready");
    tick();
    mstReq = 1'b0;
    chk(tsOut === TS_ASSERTED && tsOeN === OE_DRIVE, "no start");
    chk(tsWire === 1'b0 && mstBusy === 1'b1, "start wire");
    chk(fldOeN === OE_DRIVE && fldWire === f, "fields late");
    chk(fldOut === f, "wrong code");
    tick();
    chk(tsOut === TS_NEGATED && tsOeN === OE_DRIVE, "no negate");
    chk(fldOut.rd === rd && fldOeN === OE_DRIVE, "dir held");
    mstEnd = 1'b1;
    tick();
    mstEnd = 1'b0;
    chk(tsOeN === OE_FLOAT && fldOeN === OE_FLOAT, "no float");
    chk(mstBusy === 1'b0, "still busy");
  endtask

  // reserved size and missing bus ownership are refused
  task automatic master_refused();
    mstFields = '{addr: 32'h0000_0100, code: 4'h3, size: SIZE_THREE,
                  rd: DIR_READ};
    mstReq = 1'b1;
    #1 chk(mstReady === 1'b0, "size three taken");
    tick();
    chk(mstSizeErr === 1'b1 && tsOeN === OE_FLOAT, "no refusal");
    busOwner = 1'b0;
    mstFields.size = SIZE_ONE;
    #1 chk(mstReady === 1'b0, "taken without bus");
    tick();
    mstReq = 1'b0;
    chk(tsOeN === OE_FLOAT && fldOeN === OE_FLOAT, "drove, no bus");
    chk(mstSizeErr === 1'b0, "error held");
  endtask

  // reset in mid cycle floats the pins and idles the master
  task automatic master_reset();
    mstFields = '{addr: 32'h0000_0F00, code: 4'h9, size: SIZE_TWO,
                  rd: DIR_WRITE};
    mstReq = 1'b1;
    tick();
    mstReq = 1'b0;
    chk(tsOut === TS_ASSERTED, "no start before reset");
    rst = 1'b1;
    tick();
    chk(tsOeN === OE_FLOAT && fldOeN === OE_FLOAT, "reset drove");
    chk(tsOut === TS_NEGATED && mstBusy === 1'b0, "reset strobe");
    chk(fldOut === FIELDS_RST, "reset fields");
    tick();
    rst = 1'b0;
  endtask

  // slave cycle; select after d edges, none when d is zero
  task automatic slave_cycle(input int d, input logic regs,
                             input logic dma, input logic [1:0] sz);
    lbt_fields_t f;
    f = '{addr: 32'h1234_5670 + d, code: dma ? CODE_DMA : 4'h6,
          size: sz, rd: d[0]};
    pFld = f;
    go = 1'b1;
    dmaAcknowledgeN = !dma;
    tick();
    go = 1'b0;
    tick();
    dmaAcknowledgeN = 1'b1;
    repeat (d - 1) tick();
    if (d > 0) begin
      pciImageSelectN = regs;
      registerSelectN = !regs;
    end
    repeat (8) begin
      tick();
      if (slvValid === 1'b1 || slvMiss === 1'b1) break;
    end
    chk(slvValid === (d > 0) && slvMiss === (d == 0), "select");
    chk(slvInfo.fields === f, "capture edge");
    chk(slvInfo.fields.addr === f.addr, "address");
    chk(slvInfo.byteCount === {sz == 2'h0, sz}, "byte count");
    chk(slvInfo.isDma === dma, "dma decode");
    chk(d == 0 || slvInfo.toRegs === regs, "register hit");
    chk(tsOeN === OE_FLOAT && fldOeN === OE_FLOAT, "slave drove");
    pciImageSelectN = 1'b1;
    registerSelectN = 1'b1;
    tick();
  endtask

  initial begin
    repeat (2) tick();
    chk(tsOeN === OE_FLOAT && tsOut === TS_NEGATED, "reset");
    rst = 1'b0;
    busOwner = 1'b1;
    for (int s = 0; s < 3; s++)
      for (int r = 0; r < 2; r++)
        master_ok(2'(s), 1'(r));
    master_reset();
    master_refused();
    for (int d = 0; d < 5; d++)
      slave_cycle(d, d[0], d == 2, 2'(d));
    slave_cycle(1, 1'b0, 1'b1, SIZE_THREE);
    conclude();
  end

  initial begin
    #(4000 * CLK_PERIOD_NS);
    mismatches++;
    conclude();
  end
endmodule : tb
`default_nettype wire
